// ===== hdl/ive_pkg.sv
package ive_pkg;

    // ------------------------------------------------------------
    // register offsets on the byte-wide register port
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_ENABLE_0 = 8'h00;
    localparam logic [7:0] OFF_ENABLE_1 = 8'h01;
    localparam logic [7:0] OFF_NMI_ENABLE = 8'h02;
    localparam logic [7:0] OFF_NMI_FLAGS = 8'h03;
    localparam logic [7:0] OFF_EXT_STATUS = 8'h04;
    localparam logic [7:0] OFF_EXT_MASK = 8'h05;
    localparam logic [7:0] OFF_PEND_LO = 8'h06;
    localparam logic [7:0] OFF_PEND_HI = 8'h07;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int GLOBAL_EN_BIT = 7;
    localparam int RESERVED_EN0_BIT = 6;
    localparam logic [7:0] ENABLE_0_WMASK = 8'hbf;
    localparam logic [7:0] ENABLE_0_RESET = 8'h00;
    localparam logic [7:0] ENABLE_1_RESET = 8'h00;
    localparam logic [6:0] NMI_ENABLE_RESET = 7'h00;
    localparam logic [6:0] NMI_FLAGS_RESET = 7'h00;
    localparam logic [6:0] EXT_STATUS_RESET = 7'h00;
    localparam logic [6:0] EXT_MASK_RESET = 7'h00;

    // nonmaskable source bit positions
    localparam int NMI_WDOG = 0;
    localparam int NMI_PLL = 1;
    localparam int NMI_FLASH_TIMER = 2;
    localparam int NMI_DEBUG = 3;
    localparam int NMI_VDD = 4;
    localparam int NMI_VDDP = 5;
    localparam int NMI_ECC = 6;

    // ------------------------------------------------------------
    // sizes and vector addresses
    // ------------------------------------------------------------
    localparam int NUM_CORE_INPUTS = 14;
    localparam int NUM_NMI_SOURCES = 7;
    localparam int NUM_EXT_PINS = 7;
    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam logic [15:0] VECTOR_LAST = 16'h006b;
    localparam logic [15:0] VECTOR_NMI = 16'h0073;
    localparam logic [2:0] VECTOR_LOW_BITS = 3'h3;

endpackage

// ===== hdl/ive_interrupt_vector_enable.sv
// Notes on behaviour
// RULE_01: maskable core input n vectors to 0x0003 plus eight times n, 0..13.
// RULE_02: the nonmaskable request vectors to 0x0073 and is shared by seven events.
// RULE_03: inputs 0..5 carry ext 0, timer 0, ext 1, timer 1, serial, timer 2.
// RULE_04: input 6 converter, 7 sync serial, 8 ext 2, 9 ext 3..6, 10..13 capcom.
// RULE_05: every maskable input is gated by its own enable bit.
// RULE_06: with the global enable at bit 7 clear no maskable request goes out.
// RULE_07: first enable register holds ext0, timer0, ext1, timer1, serial, timer2.
// RULE_08: second enable register holds converter, sync, ext2, ext3to6, capcom.
// RULE_09: each nonmaskable source has its own enable bit.
// RULE_10: reset clears every enable bit in all three enable registers.
// RULE_11: bit 6 of the first enable register reads 0 and ignores writes.
// RULE_12: a pending nonmaskable request takes precedence over maskable ones.
// RULE_13: nonmaskable flags are held; a flag raises the request only if enabled.
// RULE_14: maskable request needs source, own enable and global enable.
//
// Added by the designer: the register addresses and the plain strobed port.
module ive_interrupt_vector_enable #(
    parameter int EXT_PINS = 7
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [EXT_PINS-1:0] ext_int_pin,
    input wire logic timer0_req,
    input wire logic timer1_req,
    input wire logic serial_req,
    input wire logic timer2_req,
    input wire logic [1:0] converter_request_sources,
    input wire logic sync_serial_req,
    input wire logic [3:0] capcom_req,
    input wire logic [6:0] nonmask_event,
    output logic [13:0] core_int_input_n,
    output logic nonmask_req,
    output logic [15:0] core_vector,
    output logic core_vector_valid,
    output logic irq
);

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [EXT_PINS-1:0] ext_s1;
        logic [EXT_PINS-1:0] ext_s2;
        logic [EXT_PINS-1:0] ext_prev;
        logic [7:0] enable_0;
        logic [7:0] enable_1;
        logic [6:0] nmi_enable;
        logic [6:0] nmi_flags;
        logic [6:0] ext_status;
        logic [6:0] ext_mask;
        logic [7:0] rdata;
        logic [13:0] core_req;
        logic nmi_req;
        logic [15:0] vector;
        logic vec_valid;
        logic irq;
    } ive_state_s;

    ive_state_s st_ff;
    ive_state_s nxt_st;

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------

    // vector address of a maskable core input
    function automatic logic [15:0] ive_vector_of(input logic [3:0] idx);
        ive_vector_of = ive_pkg::VECTOR_BASE + {9'h000, idx, 3'h0};
    endfunction

    // lowest numbered pending input wins among the maskable ones
    function automatic logic [3:0] ive_first_set(input logic [13:0] req);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 13; i >= 0; i--) begin
            if (req[i]) begin
                idx = 4'(i);
            end
        end
        ive_first_set = idx;
    endfunction

    // register write strobe for one offset
    function automatic logic ive_hit(input logic stb,
                                     input logic [7:0] addr,
                                     input logic [7:0] off);
        ive_hit = stb && (addr == off);
    endfunction

    // ------------------------------------------------------------
    // source routing and gating
    // ------------------------------------------------------------
    logic [EXT_PINS-1:0] ext_rise;
    logic [13:0] src_pending;
    logic [13:0] src_enable;
    logic [13:0] gated_req;
    logic [6:0] nmi_active;

    // pin edges are taken only from the second synchroniser stage
    assign ext_rise = st_ff.ext_s2 & ~st_ff.ext_prev;

    // RULE_03 low inputs map
    // RULE_04 upper inputs map
    assign src_pending = {capcom_req,
                          |st_ff.ext_status[6:3],
                          st_ff.ext_status[2],
                          sync_serial_req,
                          |converter_request_sources,
                          timer2_req,
                          serial_req,
                          timer1_req,
                          st_ff.ext_status[1],
                          timer0_req,
                          st_ff.ext_status[0]};

    // RULE_07 first register bits
    // RULE_08 second register bits
    assign src_enable = {st_ff.enable_1, st_ff.enable_0[5:0]};

    // RULE_05 per input gate
    // RULE_06 global gate
    // RULE_14 all three terms
    assign gated_req = src_pending & src_enable
                     & {14{st_ff.enable_0[ive_pkg::GLOBAL_EN_BIT]}};

    // RULE_09 per source enable
    // RULE_13 flag and enable
    assign nmi_active = st_ff.nmi_flags & st_ff.nmi_enable;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic wr_en0;
        logic wr_en1;
        logic wr_nmi_en;
        logic wr_nmi_fl;
        logic wr_ext_st;
        logic wr_ext_mk;
        logic any_nmi;
        wr_en0 = ive_hit(reg_wr, reg_addr, ive_pkg::OFF_ENABLE_0);
        wr_en1 = ive_hit(reg_wr, reg_addr, ive_pkg::OFF_ENABLE_1);
        wr_nmi_en = ive_hit(reg_wr, reg_addr, ive_pkg::OFF_NMI_ENABLE);
        wr_nmi_fl = ive_hit(reg_wr, reg_addr, ive_pkg::OFF_NMI_FLAGS);
        wr_ext_st = ive_hit(reg_wr, reg_addr, ive_pkg::OFF_EXT_STATUS);
        wr_ext_mk = ive_hit(reg_wr, reg_addr, ive_pkg::OFF_EXT_MASK);
        any_nmi = |nmi_active;
        nxt_st = st_ff;

        // two-stage synchroniser for the pins, then edge history
        nxt_st.ext_s1 = ext_int_pin;
        nxt_st.ext_s2 = st_ff.ext_s1;
        nxt_st.ext_prev = st_ff.ext_s2;

        // RULE_11 reserved bit forced low
        if (wr_en0) begin
            nxt_st.enable_0 = reg_wdata & ive_pkg::ENABLE_0_WMASK;
        end
        if (wr_en1) begin
            nxt_st.enable_1 = reg_wdata;
        end
        if (wr_nmi_en) begin
            nxt_st.nmi_enable = reg_wdata[6:0];
        end
        if (wr_ext_mk) begin
            nxt_st.ext_mask = reg_wdata[6:0];
        end

        // RULE_13 sticky event flags
        // a new event in the clearing cycle survives: set beats clear
        nxt_st.nmi_flags = (st_ff.nmi_flags
                            & ~(wr_nmi_fl ? reg_wdata[6:0] : 7'h00))
                         | nonmask_event;
        nxt_st.ext_status = (st_ff.ext_status
                             & ~(wr_ext_st ? reg_wdata[6:0] : 7'h00))
                          | 7'(ext_rise);

        // read data stands in the cycle after the strobe only
        nxt_st.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ive_pkg::OFF_ENABLE_0: begin
                    nxt_st.rdata = st_ff.enable_0
                                 & ive_pkg::ENABLE_0_WMASK;
                end
                ive_pkg::OFF_ENABLE_1: begin
                    nxt_st.rdata = st_ff.enable_1;
                end
                ive_pkg::OFF_NMI_ENABLE: begin
                    nxt_st.rdata = {1'b0, st_ff.nmi_enable};
                end
                ive_pkg::OFF_NMI_FLAGS: begin
                    nxt_st.rdata = {1'b0, st_ff.nmi_flags};
                end
                ive_pkg::OFF_EXT_STATUS: begin
                    nxt_st.rdata = {1'b0, st_ff.ext_status};
                end
                ive_pkg::OFF_EXT_MASK: begin
                    nxt_st.rdata = {1'b0, st_ff.ext_mask};
                end
                ive_pkg::OFF_PEND_LO: begin
                    nxt_st.rdata = st_ff.core_req[7:0];
                end
                ive_pkg::OFF_PEND_HI: begin
                    nxt_st.rdata = {st_ff.nmi_req, 1'b0,
                                    st_ff.core_req[13:8]};
                end
                default: begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end

        // core facing requests, registered so the core sees clean levels
        nxt_st.core_req = gated_req;
        // RULE_02 shared nonmaskable line
        nxt_st.nmi_req = any_nmi;

        // RULE_12 nonmaskable vector first
        // RULE_01 vector per input
        if (any_nmi) begin
            nxt_st.vector = ive_pkg::VECTOR_NMI;
        end else if (|gated_req) begin
            nxt_st.vector = ive_vector_of(ive_first_set(gated_req));
        end else begin
            nxt_st.vector = 16'h0000;
        end
        nxt_st.vec_valid = any_nmi || (|gated_req);

        // pin event interrupt, level while an unmasked flag stands
        nxt_st.irq = |(nxt_st.ext_status & st_ff.ext_mask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // RULE_10 all enables clear
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.enable_0 <= ive_pkg::ENABLE_0_RESET;
            st_ff.enable_1 <= ive_pkg::ENABLE_1_RESET;
            st_ff.nmi_enable <= ive_pkg::NMI_ENABLE_RESET;
            st_ff.nmi_flags <= ive_pkg::NMI_FLAGS_RESET;
            st_ff.ext_status <= ive_pkg::EXT_STATUS_RESET;
            st_ff.ext_mask <= ive_pkg::EXT_MASK_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // the core input pins are active low, one per maskable input
    assign core_int_input_n = ~st_ff.core_req;
    assign nonmask_req = st_ff.nmi_req;
    assign core_vector = st_ff.vector;
    assign core_vector_valid = st_ff.vec_valid;
    assign reg_rdata = st_ff.rdata;
    assign irq = st_ff.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence rd_first_enable_s;
        reg_rd && (reg_addr == ive_pkg::OFF_ENABLE_0);
    endsequence

    sequence wr_first_enable_s;
        reg_wr && (reg_addr == ive_pkg::OFF_ENABLE_0);
    endsequence

    reset_clears_a: assert property ( // RULE_10
        @(posedge clock) disable iff (reset)
        $past(reset) |-> (st_ff.enable_0 == 8'h00)
            && (st_ff.enable_1 == 8'h00) && (st_ff.nmi_enable == 7'h00))
        else $error("enables not clear after reset");

    global_gate_a: assert property ( // RULE_06
        @(posedge clock) disable iff (reset)
        !st_ff.enable_0[ive_pkg::GLOBAL_EN_BIT] |=> (st_ff.core_req == '0))
        else $error("maskable request with global enable clear");

    timer0_gate_a: assert property ( // RULE_05
        @(posedge clock) disable iff (reset)
        st_ff.core_req[1] |-> $past(timer0_req && st_ff.enable_0[1]
            && st_ff.enable_0[ive_pkg::GLOBAL_EN_BIT]))
        else $error("timer 0 request without its enables");

    capcom_route_a: assert property ( // RULE_04
        @(posedge clock) disable iff (reset)
        (capcom_req[3] && st_ff.enable_1[7] && st_ff.enable_0[7])
            |=> st_ff.core_req[13])
        else $error("capcom node 3 not routed to input 13");

    serial_route_a: assert property ( // RULE_03
        @(posedge clock) disable iff (reset)
        (serial_req && st_ff.enable_0[4] && st_ff.enable_0[7])
            |=> st_ff.core_req[4])
        else $error("serial request not routed to input 4");

    shared_ext_a: assert property ( // RULE_08
        @(posedge clock) disable iff (reset)
        st_ff.core_req[9] |-> $past(st_ff.enable_1[3]
            && (|st_ff.ext_status[6:3])))
        else $error("shared external input without its enable");

    nmi_enable_a: assert property ( // RULE_13
        @(posedge clock) disable iff (reset)
        nonmask_req |-> $past(|(st_ff.nmi_flags & st_ff.nmi_enable)))
        else $error("nonmaskable request from a disabled source");

    nmi_global_a: assert property ( // RULE_14
        @(posedge clock) disable iff (reset)
        (st_ff.nmi_flags[0] && st_ff.nmi_enable[0]
            && !st_ff.enable_0[ive_pkg::GLOBAL_EN_BIT]) |=> nonmask_req)
        else $error("nonmaskable request blocked by global enable");

    wdog_source_a: assert property ( // RULE_09
        @(posedge clock) disable iff (reset)
        (st_ff.nmi_flags == 7'h01 && !st_ff.nmi_enable[0])
            |=> !nonmask_req)
        else $error("disabled watchdog source raised a request");

    nmi_first_a: assert property ( // RULE_12
        @(posedge clock) disable iff (reset)
        nonmask_req |-> (core_vector == ive_pkg::VECTOR_NMI)
            && core_vector_valid)
        else $error("nonmaskable vector did not take precedence");

    mask_vector_a: assert property ( // RULE_01
        @(posedge clock) disable iff (reset)
        (core_vector_valid && !nonmask_req) |->
            (core_vector[2:0] == ive_pkg::VECTOR_LOW_BITS)
            && (core_vector <= ive_pkg::VECTOR_LAST))
        else $error("maskable vector outside the table");

    ext0_vector_a: assert property ( // RULE_01
        @(posedge clock) disable iff (reset)
        (st_ff.core_req[0] && !nonmask_req) |->
            (core_vector == ive_pkg::VECTOR_BASE))
        else $error("input 0 pending but vector differs");

    reserved_bit_a: assert property ( // RULE_11
        @(posedge clock) disable iff (reset)
        wr_first_enable_s ##1 rd_first_enable_s |=> (reg_rdata[6] == 1'b0))
        else $error("reserved enable bit read back as one");

    enable_write_a: assert property ( // RULE_07
        @(posedge clock) disable iff (reset)
        wr_first_enable_s |=> (st_ff.enable_0[5:0] == $past(reg_wdata[5:0])))
        else $error("first enable register did not take the write");

endmodule

// ===== tb/ive_core_model.sv
module ive_core_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic [13:0] core_int_input_n,
    input wire logic nonmask_req,
    input wire logic [15:0] core_vector,
    output logic [15:0] taken_vector
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // core acceptance
    // ------------------------------------------------------------
    // the core trusts the request lines, not the valid flag, so a
    // vector that lags its request shows up as a wrong capture
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            taken_vector <= 16'h0000;
        end else if (nonmask_req || !(&core_int_input_n)) begin
            taken_vector <= core_vector;
        end
    end
endmodule

// ===== tb/interrupt_vector_enable_bench.sv
module interrupt_vector_enable_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [6:0] ext_int_pin = 7'h00;
    logic timer0_req = 1'b0;
    logic timer1_req = 1'b0;
    logic serial_req = 1'b0;
    logic timer2_req = 1'b0;
    logic sync_serial_req = 1'b0;
    logic [1:0] converter_request_sources = 2'h0;
    logic [3:0] capcom_req = 4'h0;
    logic [6:0] nonmask_event = 7'h00;
    logic [7:0] reg_rdata;
    logic [13:0] core_int_input_n;
    logic nonmask_req;
    logic core_vector_valid;
    logic irq;
    logic [15:0] core_vector;
    logic [15:0] taken_vector;
    // bench model of the register state
    logic [7:0] m_en0 = 8'h00;
    logic [7:0] m_en1 = 8'h00;
    logic [6:0] m_nen = 7'h00;
    logic [6:0] m_nflag = 7'h00;
    logic [6:0] m_ext = 7'h00;
    logic [6:0] m_mask = 7'h00;
    logic [13:0] oh;
    int err_total = 0;
    int checks_done = 0;
    int seed = 52;

    // 100 MHz clock
    always #5 clock = ~clock;

    ive_interrupt_vector_enable #(.EXT_PINS(7)) i_dut (
        .clock(clock), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_int_pin(ext_int_pin),
        .timer0_req(timer0_req), .timer1_req(timer1_req),
        .serial_req(serial_req), .timer2_req(timer2_req),
        .converter_request_sources(converter_request_sources),
        .sync_serial_req(sync_serial_req), .capcom_req(capcom_req),
        .nonmask_event(nonmask_event),
        .core_int_input_n(core_int_input_n), .nonmask_req(nonmask_req),
        .core_vector(core_vector), .core_vector_valid(core_vector_valid),
        .irq(irq)
    );

    ive_core_model i_core (
        .clock(clock), .reset(reset), .core_int_input_n(core_int_input_n),
        .nonmask_req(nonmask_req), .core_vector(core_vector),
        .taken_vector(taken_vector)
    );

    // ------------------------------------------------------------
    // model and checking helpers
    // ------------------------------------------------------------
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function logic [13:0] exp_gate();
        logic [13:0] req;
        req = {capcom_req, |m_ext[6:3], m_ext[2], sync_serial_req,
               |converter_request_sources, timer2_req, serial_req,
               timer1_req, m_ext[1], timer0_req, m_ext[0]};
        return req & {m_en1, m_en0[5:0]} & {14{m_en0[7]}};
    endfunction

    function logic [15:0] exp_vec(input logic [13:0] g, input logic nm);
        if (nm) return 16'h0073;
        for (int i = 0; i < 14; i++) if (g[i]) return 16'h0003 + 16'(8 * i);
        return 16'h0000;
    endfunction

    function logic [7:0] exp_reg(input logic [7:0] a);
        logic [13:0] g;
        g = exp_gate();
        case (a)
            8'h00: return m_en0;
            8'h01: return m_en1;
            8'h02: return {1'b0, m_nen};
            8'h03: return {1'b0, m_nflag};
            8'h04: return {1'b0, m_ext};
            8'h05: return {1'b0, m_mask};
            8'h06: return g[7:0];
            8'h07: return {|(m_nflag & m_nen), 1'b0, g[13:8]};
            default: return 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // bus and stimulus tasks
    // ------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        case (a)
            8'h00: m_en0 = d & 8'hbf;
            8'h01: m_en1 = d;
            8'h02: m_nen = d[6:0];
            8'h03: m_nflag = m_nflag & ~d[6:0];
            8'h04: m_ext = m_ext & ~d[6:0];
            8'h05: m_mask = d[6:0];
            default: ;
        endcase
    endtask

    task rd(input logic [7:0] a);
        logic [7:0] e;
        e = exp_reg(a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, e});
        // read data must fall back to zero one cycle later
        @(posedge clock);
        #1;
        chk({8'h00, reg_rdata}, 16'h0000);
    endtask

    task srcs(input logic [13:0] s, input logic [1:0] cv);
        @(posedge clock);
        timer0_req <= s[1];
        timer1_req <= s[3];
        serial_req <= s[4];
        timer2_req <= s[5];
        converter_request_sources <= cv;
        sync_serial_req <= s[7];
        capcom_req <= s[13:10];
    endtask

    // pin held high two cycles so the synchroniser sees the edge
    task pin(input int p);
        @(posedge clock);
        ext_int_pin[p] <= 1'b1;
        repeat (2) @(posedge clock);
        ext_int_pin[p] <= 1'b0;
        m_ext[p] = 1'b1;
    endtask

    task pulse(input logic [6:0] e);
        @(posedge clock);
        nonmask_event <= e;
        @(posedge clock);
        nonmask_event <= 7'h00;
        m_nflag = m_nflag | e;
    endtask

    // six edges cover the pin synchroniser plus the output register
    task check_outs;
        logic [13:0] g;
        logic nm;
        repeat (6) @(posedge clock);
        #1;
        g = exp_gate();
        nm = |(m_nflag & m_nen);
        chk({2'h0, core_int_input_n}, {2'h0, ~g});
        chk({15'h0, nonmask_req}, {15'h0, nm});
        chk(core_vector, exp_vec(g, nm));
        chk({15'h0, core_vector_valid}, {15'h0, nm | (|g)});
        chk({15'h0, irq}, {15'h0, |(m_ext & m_mask)});
        if (nm | (|g)) chk(taken_vector, exp_vec(g, nm));
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        for (int a = 0; a < 10; a++) rd(8'(a));
        rd(8'hff);
        check_outs;
        $display("test reset done");
        for (int a = 0; a < 6; a++) wr(8'(a), 8'hff);
        for (int a = 0; a < 10; a++) rd(8'(a));
        // write then read of the first enable register, no idle cycle
        @(posedge clock);
        reg_addr <= 8'h00;
        reg_wdata <= 8'hff;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        m_en0 = 8'hbf;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, m_en0});
        wr(8'h02, 8'h00);
        $display("test access done");
        // descending pins: pins 6 to 3 share input 9, then pins 2, 1 and 0 each lower the vector
        for (int p = 6; p >= 0; p--) begin
            pin(p);
            check_outs;
        end
        wr(8'h05, 8'h05);
        check_outs;
        wr(8'h04, 8'h05);
        check_outs;
        pin(0);
        pin(2);
        $display("test ext done");
        srcs(14'h3fff, 2'h2);
        wr(8'h00, 8'h3f);
        check_outs;
        for (int i = 0; i < 14; i++) begin
            oh = 14'h0001 << i;
            wr(8'h00, {2'b10, oh[5:0]});
            wr(8'h01, oh[13:6]);
            check_outs;
        end
        $display("test gate done");
        wr(8'h01, 8'hff);
        for (int k = 0; k < 7; k++) begin
            wr(8'h00, k[0] ? 8'hbf : 8'h3f);
            wr(8'h02, 8'(1 << k));
            pulse(7'(1 << ((k + 1) % 7)));
            check_outs;
            pulse(7'(1 << k));
            check_outs;
            rd(8'h03);
            wr(8'h03, 8'h7f);
            check_outs;
        end
        $display("test nonmask done");
        repeat (60) begin
            wr(8'h00, 8'($random(seed)));
            wr(8'h01, 8'($random(seed)));
            wr(8'h02, 8'($random(seed)));
            srcs(14'($random(seed)), 2'($random(seed)));
            pulse(7'($random(seed)) & 7'($random(seed)));
            check_outs;
            rd(8'($random(seed)) & 8'h07);
            wr(8'h03, 8'($random(seed)));
        end
        $display("test random done");
        test_done;
    end

    // watchdog: the sequence needs well under 10000 cycles
    initial begin
        #200us;
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        test_done;
    end
endmodule
